/* verilog/wdir_watchdog.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Time-out with interrupt enabled sets flag.
// - Taking the interrupt vector clears flag.
// - Software writing one clears flag; zero keeps.
// - Request only when flag, enable, global enable.
// - Interrupt-only mode never resets the system.
// - Combined mode: first time-out only sets flag.
// - Combined mode vector clears enable and flag.
// - Unserviced combined time-out asserts system reset.
// - Register layout and reset values as listed.
// - Counter runs from dedicated watchdog oscillator.
// ---------------------------------------------------------------------------
// Watchdog timer with interrupt, reset and combined modes.
// ---------------------------------------------------------------------------
module wdir_watchdog
  import wdir_pkg::*;
#(
  parameter int unsigned PERIOD_TICKS = PERIOD_BASE  // Ticks at period code 0.
)
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [DATA_W-1:0] regRdData,
  // Processor side.
  input  wire logic              globalIrqEnable,
  input  wire logic              vectorAck,
  input  wire logic              wdtRestart,
  output var  logic              wdtIrqReq,
  // Reset generator and oscillator.
  input  wire logic              wdtOscIn,
  output var  logic              sysResetReq,
  // Event interrupt.
  output var  logic              irqOut
);

  // -------------------------------------------------------------------------
  // Declarations.
  // -------------------------------------------------------------------------
  logic             flag_q;        // Time-out flag.
  logic             ie_q;          // Time-out interrupt enable.
  logic             re_q;          // System reset enable.
  logic             ce_q;          // Change enable, stored only.
  logic [3:0]       psel_q;        // Period select, high bit first.
  logic [CNT_W-1:0] cnt_q;         // Oscillator tick counter.
  logic [CNT_W-1:0] cntInc;        // Counter plus one.
  logic             oscTick;       // One pulse per rising oscillator edge.
  logic             toHit;         // Time-out in this cycle.
  logic             wrCsr;         // Write to the control/status register.
  logic             flagSet;       // Hardware sets the flag.
  logic             flagClr;       // Vector or software clears the flag.
  logic             rstFire;       // Time-out asks for a system reset.
  logic             irqCond;       // Processor interrupt condition.
  logic [7:0]       csrVal;        // Assembled control/status image.
  logic [EVT_W-1:0] evtStat_q;     // Sticky event status.
  logic [EVT_W-1:0] evtEn_q;       // Event interrupt enable.
  logic [EVT_W-1:0] evtSet;        // Events raised this cycle.
  logic [EVT_W-1:0] evtClr;        // Clear requests this cycle.

  // Period at code 0, sized to the counter width.
  localparam logic [CNT_W-1:0] PERIOD0 = CNT_W'(PERIOD_TICKS);

  // -------------------------------------------------------------------------
  // Helper functions.
  // -------------------------------------------------------------------------
  // Turns a period code into a tick count; codes above the top are clamped.
  function automatic logic [CNT_W-1:0] periodLimit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > SEL_MAX) ? SEL_MAX : sel;
    return PERIOD0 << s;
  endfunction : periodLimit

  // Decodes one register offset against a write or read strobe.
  function automatic logic hitReg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off,
                                  input logic strobe);
    return strobe && (a == off);
  endfunction : hitReg

  // -------------------------------------------------------------------------
  // Oscillator tick.
  // -------------------------------------------------------------------------
  // The counter runs on the watchdog oscillator, whatever clocks the core.
  wdir_osc_tick uOscTick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .oscIn   (wdtOscIn),
    .oscTick (oscTick)
  );

  // -------------------------------------------------------------------------
  // Counter and time-out.
  // -------------------------------------------------------------------------
  // The compare is greater-or-equal, so a shorter period that is already
  // passed fires at the next tick; software should restart first.
  always_comb begin
    cntInc = cnt_q + CNT_W'(1);
    toHit  = oscTick && !wdtRestart && (cntInc >= periodLimit(psel_q));
  end

  // Restart wins over the tick, so a full period always follows it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (wdtRestart) begin
      cnt_q <= '0;
    end else if (toHit) begin
      cnt_q <= '0;
    end else if (oscTick) begin
      cnt_q <= cntInc;
    end
  end

  // -------------------------------------------------------------------------
  // Mode decisions.
  // -------------------------------------------------------------------------
  // Decodes the mode bits into flag set, flag clear, reset and request terms.
  always_comb begin
    wrCsr   = hitReg(regAddr, OFF_CSR, regWr);
    // Interrupt operation sets the flag; in combined mode only the first.
    flagSet = toHit && ie_q && !(re_q && flag_q);
    // Reset-only mode, or combined mode with the flag still pending.
    rstFire = toHit && re_q && (!ie_q || flag_q);
    flagClr = vectorAck || (wrCsr && regWrData[CSR_FLAG_BIT]);
    irqCond = flag_q && ie_q && globalIrqEnable;
  end

  // -------------------------------------------------------------------------
  // Control/status register.
  // -------------------------------------------------------------------------
  // Flag: a set in the same cycle as a clear wins, so no time-out is lost.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= CSR_RESET[CSR_FLAG_BIT];
    end else if (flagSet) begin
      flag_q <= 1'h1;
    end else if (flagClr) begin
      flag_q <= 1'h0;
    end
  end

  // Interrupt enable: the vector in combined mode drops to reset-only mode.
  // Software must write it again to stay combined; a write that lands in
  // the vector cycle wins, since it is the newer intent.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= CSR_RESET[CSR_IE_BIT];
    end else if (wrCsr) begin
      ie_q <= regWrData[CSR_IE_BIT];
    end else if (vectorAck && re_q) begin
      ie_q <= 1'h0;
    end
  end

  // Remaining plain fields of the control/status register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      re_q   <= CSR_RESET[CSR_RE_BIT];
      ce_q   <= CSR_RESET[CSR_CE_BIT];
      psel_q <= {CSR_RESET[CSR_PSHI_BIT], CSR_RESET[CSR_PSLO_MSB:0]};
    end else if (wrCsr) begin
      re_q   <= regWrData[CSR_RE_BIT];
      ce_q   <= regWrData[CSR_CE_BIT];
      psel_q <= {regWrData[CSR_PSHI_BIT], regWrData[CSR_PSLO_MSB:0]};
    end
  end

  // Image of the register in its documented bit order.
  always_comb begin
    csrVal = {flag_q, ie_q, psel_q[3], ce_q, re_q, psel_q[2:0]};
  end

  // -------------------------------------------------------------------------
  // Processor interrupt request and system reset.
  // -------------------------------------------------------------------------
  // Both outputs come straight from flip-flops, one cycle after the cause.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdtIrqReq   <= 1'h0;
      sysResetReq <= 1'h0;
    end else begin
      wdtIrqReq   <= irqCond;
      sysResetReq <= rstFire;
    end
  end

  // -------------------------------------------------------------------------
  // Event status, clear and enable.
  // -------------------------------------------------------------------------
  // Collects this cycle's events and the software clear mask.
  always_comb begin
    evtSet = '0;
    evtSet[EVT_TIMEOUT] = toHit;
    evtSet[EVT_SYSRST]  = rstFire;
    evtSet[EVT_VECTOR]  = vectorAck;
    evtClr = hitReg(regAddr, OFF_EVT_CLR, regWr) ? regWrData[EVT_W-1:0] : '0;
  end

  // One sticky bit per event; set beats clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++) begin : gEvt
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          evtStat_q[gi] <= EVT_RESET[gi];
        end else if (evtSet[gi]) begin
          evtStat_q[gi] <= 1'h1;
        end else if (evtClr[gi]) begin
          evtStat_q[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  // Enable register for the event interrupt.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evtEn_q <= EVT_RESET;
    end else if (hitReg(regAddr, OFF_EVT_EN, regWr)) begin
      evtEn_q <= regWrData[EVT_W-1:0];
    end
  end

  // Level interrupt while any enabled event bit is set.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqOut <= 1'h0;
    end else begin
      irqOut <= |(evtStat_q & evtEn_q);
    end
  end

  // -------------------------------------------------------------------------
  // Read data.
  // -------------------------------------------------------------------------
  // Read data stands for one cycle only; unmapped offsets read as zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFF_CSR:      regRdData <= csrVal;
        OFF_EVT_STAT: regRdData <= {{(DATA_W-EVT_W){1'h0}}, evtStat_q};
        OFF_EVT_EN:   regRdData <= {{(DATA_W-EVT_W){1'h0}}, evtEn_q};
        default:      regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions.
  // -------------------------------------------------------------------------
  default clocking cbAst @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // A time-out seen in combined mode with the flag still clear.
  sequence seqFirstComb;
    toHit && ie_q && re_q && !flag_q;
  endsequence

  // The outcome of a first combined time-out: flag up, no reset.
  sequence seqFlagOnly;
    flag_q && !sysResetReq;
  endsequence

  // A time-out that must end in a system reset.
  sequence seqResetDue;
    toHit && re_q && (flag_q || !ie_q);
  endsequence

  AST_FLAG_SET: assert property (toHit && ie_q && !flag_q |=> flag_q)
    else $error("Time-out with interrupt enabled left the flag clear.");

  AST_VEC_CLR: assert property (vectorAck && !flagSet |=> !flag_q)
    else $error("Vector did not clear the time-out flag.");

  AST_SW_CLR: assert property (wrCsr && regWrData[7] && !flagSet |=> !flag_q)
    else $error("Writing one did not clear the time-out flag.");

  AST_SW_KEEP: assert property (
    wrCsr && !regWrData[7] && !vectorAck && flag_q |=> flag_q)
    else $error("Writing zero disturbed the time-out flag.");

  AST_IRQ_REQ: assert property (##1 wdtIrqReq == $past(irqCond))
    else $error("Interrupt request does not follow flag and enables.");

  AST_INT_ONLY: assert property (toHit && ie_q && !re_q |=> !sysResetReq)
    else $error("Interrupt-only mode requested a system reset.");

  AST_FIRST_COMB: assert property (seqFirstComb |=> seqFlagOnly)
    else $error("First combined time-out did more than set the flag.");

  AST_VEC_COMB: assert property (
    vectorAck && re_q && !wrCsr && !flagSet |=> !ie_q && !flag_q)
    else $error("Combined mode vector left enable or flag set.");

  AST_RESET_DUE: assert property (seqResetDue |=> sysResetReq ##1 !sysResetReq)
    else $error("Due system reset was not a single pulse.");

  AST_ALL_OFF: assert property (
    toHit && !ie_q && !re_q && !flag_q |=> !sysResetReq && !flag_q)
    else $error("Watchdog acted with both enables clear.");

  AST_RESTART: assert property (wdtRestart |=> cnt_q == '0 ##1 !toHit)
    else $error("Restart did not clear the counter.");

  AST_OSC_ONLY: assert property (!oscTick |=> $stable(cnt_q) || cnt_q == '0)
    else $error("Counter moved without an oscillator tick.");

  AST_CSR_READ: assert property (
    regRd && regAddr == OFF_CSR |=> regRdData == $past(csrVal))
    else $error("Control/status read returned a wrong image.");

  // Every time-out leaves its sticky event bit set, whatever the mode.
  AST_EVT_STICKY: assert property (toHit |=> evtStat_q[EVT_TIMEOUT])
    else $error("Time-out did not set its event status bit.");

  // An enabled pending event must show on the level interrupt next cycle.
  AST_EVT_IRQ: assert property ((|(evtStat_q & evtEn_q)) |=> irqOut)
    else $error("Enabled event did not raise the event interrupt.");

  // Read data is zero outside the cycle after a read strobe.
  AST_RDATA_IDLE: assert property (!regRd |=> regRdData == '0)
    else $error("Read data stood outside its one-cycle slot.");

  // Without the reset enable no time-out may ever reach the reset line.
  AST_NO_RE_RST: assert property (toHit && !re_q |=> !sysResetReq)
    else $error("Time-out requested a reset with reset enable clear.");

endmodule : wdir_watchdog
`default_nettype wire

/* pkg/wdir_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants of the watchdog interrupt/reset block.
// ---------------------------------------------------------------------------
package wdir_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_CSR      = 4'h0;  // Watchdog control/status.
  localparam logic [3:0] OFF_EVT_STAT = 4'h1;  // Sticky event status, read only.
  localparam logic [3:0] OFF_EVT_CLR  = 4'h2;  // Event clear, write only.
  localparam logic [3:0] OFF_EVT_EN   = 4'h3;  // Event interrupt enable.

  // Field positions inside the control/status register.
  localparam int unsigned CSR_FLAG_BIT   = 7;  // Time-out flag.
  localparam int unsigned CSR_IE_BIT     = 6;  // Time-out interrupt enable.
  localparam int unsigned CSR_PSHI_BIT   = 5;  // Period select, high bit.
  localparam int unsigned CSR_CE_BIT     = 4;  // Change enable.
  localparam int unsigned CSR_RE_BIT     = 3;  // System reset enable.
  localparam int unsigned CSR_PSLO_MSB   = 2;  // Period select, low bits 2:0.

  // Reset values; the reset enable bit has no defined value, zero is used.
  localparam logic [7:0] CSR_RESET     = 8'h00;
  localparam logic [2:0] EVT_RESET     = 3'h0;

  // Event bits of the status, clear and enable registers.
  localparam int unsigned EVT_W        = 3;
  localparam int unsigned EVT_TIMEOUT  = 0;  // Any counter time-out.
  localparam int unsigned EVT_SYSRST   = 1;  // A system reset was requested.
  localparam int unsigned EVT_VECTOR   = 2;  // The interrupt vector was taken.

  // Counter sizing and period selection.
  localparam int unsigned CNT_W        = 24;
  localparam logic [3:0]  SEL_MAX      = 4'h9;  // Larger codes act as this one.
  localparam int unsigned PERIOD_BASE  = 2048;  // Oscillator ticks at code zero.

endpackage : wdir_pkg

/* verilog/wdir_osc_tick.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Watchdog oscillator synchroniser and rising edge detector.
// ---------------------------------------------------------------------------
module wdir_osc_tick
  import wdir_pkg::*;
(
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_n,
  // Raw oscillator pin and the derived enable pulse.
  input  wire logic oscIn,
  output var  logic oscTick
);

  logic syncA_q;  // First stage, read only by the second stage.
  logic syncB_q;  // Second stage, first safe copy.
  logic prev_q;   // Delayed copy for the edge detector.

  // Two flip-flops guard against metastability, a third finds the edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 1'h0;
      syncB_q <= 1'h0;
      prev_q  <= 1'h0;
    end else begin
      syncA_q <= oscIn;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end

  // One-cycle enable on each rising oscillator edge.
  always_comb begin
    oscTick = syncB_q & ~prev_q;
  end

endmodule : wdir_osc_tick
`default_nettype wire

/* test/wdir_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Processor interrupt logic and system reset generator model.
// ---------------------------------------------------------------------------
module wdir_cpu_model (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Lines from the watchdog and the bench control.
  input  wire logic       wdtIrqReq,
  input  wire logic       sysResetReq,
  input  wire logic       ackEnable,
  // Vector taken pulse and count of resets seen.
  output var  logic       vectorAck,
  output var  logic [7:0] resetCnt
);
  logic ackBusy;  // High from a taken vector until the request falls.

  // Takes the vector once per request; waits for the request to drop so a
  // slow flag clear is never mistaken for a second interrupt.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vectorAck <= 1'h0;
      ackBusy   <= 1'h0;
    end else begin
      vectorAck <= wdtIrqReq && ackEnable && !ackBusy && !vectorAck;
      if (vectorAck) begin
        ackBusy <= 1'h1;
      end else if (!wdtIrqReq) begin
        ackBusy <= 1'h0;
      end
    end
  end

  // The reset generator counts every request pulse it receives.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resetCnt <= 8'h00;
    end else if (sysResetReq) begin
      resetCnt <= resetCnt + 8'h01;
    end
  end
endmodule : wdir_cpu_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Self-checking bench of the watchdog block.
// ---------------------------------------------------------------------------
module tb
  import wdir_pkg::*;
;
  localparam int unsigned TICKS = 4;  // Short period keeps each code-0 time-out at 32 cycles.
  logic       mclk, rst_n, regWr, regRd, gie, wdtRestart, oscRun, ackEn;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, resetCnt, d, old;
  logic [2:0] oscDiv = 3'h0;  // Oscillator divider: one tick every 8 cycles.
  logic       vectorAck, wdtIrqReq, sysResetReq, irqOut;
  wire        wdtOscIn = oscDiv[2];
  int         errorCnt, numChecks;

  wdir_watchdog #(.PERIOD_TICKS(TICKS)) wdir_watchdog_inst (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .globalIrqEnable(gie),
    .vectorAck(vectorAck), .wdtRestart(wdtRestart), .wdtIrqReq(wdtIrqReq),
    .wdtOscIn(wdtOscIn), .sysResetReq(sysResetReq), .irqOut(irqOut));
  wdir_cpu_model wdir_cpu_model_inst (
    .mclk(mclk), .rst_n(rst_n), .wdtIrqReq(wdtIrqReq), .sysResetReq(sysResetReq),
    .ackEnable(ackEn), .vectorAck(vectorAck), .resetCnt(resetCnt));

  // ---------------------------------------------------------------------------
  // Clock and oscillator.
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Stopping the oscillator freezes time-outs so flags can be read calmly.
  always @(posedge mclk) if (oscRun) oscDiv <= oscDiv + 3'h1;

  // ---------------------------------------------------------------------------
  // Shared tasks; every task that drives or waits is entered just after a rising edge.
  // ---------------------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // The idle cycle after a write keeps the strobe from being set twice at one edge.
  task wr(input logic [3:0] a, input logic [7:0] v);
    regAddr <= a; regWrData <= v; regWr <= 1'h1;
    @(posedge mclk); regWr <= 1'h0;
    @(posedge mclk);
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] v);
    regAddr <= a; regRd <= 1'h1;
    @(posedge mclk); regRd <= 1'h0;
    #1 v = regRdData;
    @(posedge mclk);
  endtask : rd
  // Bounded waits sample away from the edge, then realign.
  task waitIrq(input logic lvl);
    for (int i = 0; i < 400 && wdtIrqReq !== lvl; i++) @(negedge mclk);
    chk("wdtIrqReq", {7'h00, lvl}, {7'h00, wdtIrqReq});
    @(posedge mclk);
  endtask : waitIrq
  task waitRst(input logic [7:0] was);
    for (int i = 0; i < 400 && resetCnt === was; i++) @(negedge mclk);
    @(posedge mclk);
  endtask : waitRst

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task t_reset;
    rd(OFF_CSR, d); chk("csr reset", CSR_RESET, d);
    rd(4'hf, d); chk("unmapped", 8'h00, d);
    wr(OFF_CSR, 8'h77); rd(OFF_CSR, d); chk("csr fields", 8'h77, d);
    wr(OFF_CSR, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task t_irq;
    wr(OFF_EVT_EN, 8'h07); wr(OFF_CSR, 8'h40);
    gie <= 1'h1; old = resetCnt; oscRun <= 1'h1;
    waitIrq(1'h1);
    oscRun <= 1'h0;
    rd(OFF_CSR, d); chk("flag set", 8'hc0, d);
    chk("irqOut", 8'h01, {7'h00, irqOut});
    gie <= 1'h0; waitIrq(1'h0);
    gie <= 1'h1; waitIrq(1'h1);
    ackEn <= 1'h1; waitIrq(1'h0); ackEn <= 1'h0;
    rd(OFF_CSR, d); chk("flag by vector", 8'h40, d);
    chk("no reset", old, resetCnt);
    rd(OFF_EVT_STAT, d); chk("evtStat", 8'h05, d);
    wr(OFF_EVT_CLR, 8'h07); rd(OFF_EVT_STAT, d); chk("evtStat clr", 8'h00, d);
    @(negedge mclk); chk("irqOut clr", 8'h00, {7'h00, irqOut});
    @(posedge mclk);
    $display("t_irq done");
  endtask : t_irq
  task t_w1c;
    gie <= 1'h0; oscRun <= 1'h1;
    for (int i = 0; i < 20; i++) begin
      rd(OFF_CSR, d);
      if (d[7]) break;
      cyc(8);
    end
    oscRun <= 1'h0;
    chk("flag", 8'hc0, d);
    @(negedge mclk); chk("gie low", 8'h00, {7'h00, wdtIrqReq});
    @(posedge mclk);
    wr(OFF_CSR, 8'h40); rd(OFF_CSR, d); chk("write zero", 8'hc0, d);
    wr(OFF_CSR, 8'hc0); rd(OFF_CSR, d); chk("write one", 8'h40, d);
    $display("t_w1c done");
  endtask : t_w1c
  // Unserviced reset, vector, software re-arm, then reset-only time-out.
  task t_comb;
    wr(OFF_CSR, 8'h48);
    gie <= 1'h1;
    old = resetCnt;
    oscRun <= 1'h1;
    waitIrq(1'h1);
    oscRun <= 1'h0;
    chk("first timeout", old, resetCnt);
    rd(OFF_CSR, d);
    chk("combined flag", 8'hc8, d);
    oscRun <= 1'h1;
    waitRst(old);
    oscRun <= 1'h0;
    chk("unserviced reset", old + 8'h01, resetCnt);
    rd(OFF_CSR, d);
    chk("flag kept", 8'hc8, d);
    ackEn <= 1'h1;
    waitIrq(1'h0);
    ackEn <= 1'h0;
    rd(OFF_CSR, d);
    chk("vector clears", 8'h08, d);
    wr(OFF_CSR, 8'h48);
    oscRun <= 1'h1;
    waitIrq(1'h1);
    oscRun <= 1'h0;
    chk("rearmed", old + 8'h01, resetCnt);
    ackEn <= 1'h1;
    waitIrq(1'h0);
    ackEn <= 1'h0;
    oscRun <= 1'h1;
    waitRst(old + 8'h01);
    oscRun <= 1'h0;
    chk("reset count", old + 8'h02, resetCnt);
    wr(OFF_CSR, 8'h00);
    $display("t_comb done");
  endtask : t_comb
  // Five ticks under the longer period, then a switch to the shorter one
  // without a restart: the next tick must already time out.
  task t_short;
    gie <= 1'h0;
    wr(OFF_CSR, 8'h41);
    wdtRestart <= 1'h1;
    oscRun <= 1'h1;
    @(posedge mclk);
    wdtRestart <= 1'h0;
    cyc(39);
    oscRun <= 1'h0;
    rd(OFF_CSR, d);
    chk("long period", 8'h41, d);
    wr(OFF_CSR, 8'h40);
    rd(OFF_CSR, d);
    chk("no tick", 8'h40, d);
    oscRun <= 1'h1;
    cyc(16);
    oscRun <= 1'h0;
    rd(OFF_CSR, d);
    chk("short period", 8'hc0, d);
    wr(OFF_CSR, 8'h80);
    rd(OFF_CSR, d);
    chk("cleared", 8'h00, d);
    $display("t_short done");
  endtask : t_short
  task t_quiet;
    wr(OFF_CSR, 8'h40); cyc(200);
    rd(OFF_CSR, d); chk("osc stopped", 8'h40, d);
    oscRun <= 1'h1;
    repeat (12) begin
      wdtRestart <= 1'h1; @(posedge mclk); wdtRestart <= 1'h0; cyc(15);
    end
    rd(OFF_CSR, d); chk("restarted", 8'h40, d);
    wr(OFF_CSR, 8'h00); old = resetCnt; cyc(200);
    rd(OFF_CSR, d); chk("disabled", 8'h00, d);
    chk("disabled reset", old, resetCnt);
    oscRun <= 1'h0;
    $display("t_quiet done");
  endtask : t_quiet

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, regWr, regRd, gie, wdtRestart, oscRun, ackEn} = 7'h00;
    {regAddr, regWrData} = 12'h000;
    errorCnt = 0;
    numChecks = 0;
    cyc(2);
    rst_n <= 1'h1;
    @(posedge mclk);
    t_reset(); t_irq(); t_w1c(); t_comb(); t_short(); t_quiet();
    end_of_test();
  end
  initial begin
    #100000;
    errorCnt++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
